// file: core/sih_status.sv
// Status pin, sticky interrupts, cable length/mute and host port straps.
// Assumes register requests arrive decoded from the serial port, one per
// cycle, synchronous to clk; analog status inputs are already synchronous.
//
// Contract
// - Status pin is active-low open drain
// - Default role: pin low when recovery locked
// - Register selects lock, carrier or interrupt role
// - Carrier role: low after detect and adaptation
// - Register picks cable or trace carrier
// - Interrupt role: low on any enabled event
// - Cable signal loss has two masks
// - Trace signal loss has two masks
// - Eye below threshold while locked, one mask
// - Lock event has two masks
// - Sticky interrupt cleared by status read
// - Cable length reading 0..55 at 0x25
// - Mute threshold field at 0x03
// - Port select strap sampled at power-up
// - SMBus mode reuses pins, samples address straps
// - Address is 0x1D plus 4*first plus second
// - Write command is address shifted, LSB zero
`timescale 1ns/10ps

module sih_status #(
    parameter int LEN_W = sih_pkg::LEN_W
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire sih_pkg::sih_reg_req_t  reg_req,
    output logic [sih_pkg::DW-1:0]      reg_rdata,
    output logic                        reg_rvalid,
    input  wire sih_pkg::sih_link_t     link,
    input  wire logic [LEN_W-1:0]       horizontal_eye_width,
    input  wire logic [LEN_W-1:0]       vertical_eye_height,
    input  wire logic [LEN_W-1:0]       cable_length_raw,
    input  wire logic [1:0]             mode_sel_level,
    input  wire logic [1:0]             addr_strap_first,
    input  wire logic [1:0]             addr_strap_second,
    input  wire logic                   status_pin_i,
    output logic                        status_pin_o,
    output logic                        status_pin_oe,
    output logic                        outputs_muted,
    output sih_pkg::sih_host_port_t     host_port
);

    // Register state
    logic [LEN_W-1:0]         mute_length_threshold;
    logic [LEN_W-1:0]         next_mute_length_threshold;
    logic [LEN_W-1:0]         cable_length_reading;
    logic [LEN_W-1:0]         next_cable_length_reading;
    logic [2:0]               pin_cfg;
    logic [2:0]               next_pin_cfg;
    logic [sih_pkg::EV_N-1:0] int_mask;
    logic [sih_pkg::EV_N-1:0] next_int_mask;
    logic [sih_pkg::EV_N-1:0] int_status;
    logic [sih_pkg::EV_N-1:0] next_int_status;
    logic [LEN_W-1:0]         heye_thr;
    logic [LEN_W-1:0]         next_heye_thr;
    logic [LEN_W-1:0]         veye_thr;
    logic [LEN_W-1:0]         next_veye_thr;
    logic [sih_pkg::DW-1:0]   next_reg_rdata;
    logic                     next_reg_rvalid;

    // Edge history
    logic prev_lock;
    logic prev_cable_loss;
    logic prev_trace_loss;
    logic prev_eye_low;
    logic eye_low;

    // Pin and mute state
    logic carrier_found_n;
    logic next_status_pin_oe;
    logic next_outputs_muted;
    logic [sih_pkg::EV_N-1:0] events;
    sih_pkg::sih_role_t       role;
    sih_pkg::sih_host_port_t  next_host_port;

    function automatic logic is_addr(input logic [7:0] a,
                                     input logic [7:0] ofs);
        is_addr = (a == ofs);
    endfunction

    // Strap pins settle to one of four levels before reset releases
    function automatic logic level_is(input logic [1:0]         lvl,
                                      input sih_pkg::sih_level_t code);
        level_is = (lvl == code);
    endfunction

    assign role = sih_pkg::sih_role_t'(pin_cfg[sih_pkg::CFG_ROLE_LSB +: 2]);

    // Event detection
    always_comb begin
        eye_low = link.cdr_locked &&
                  ((horizontal_eye_width < heye_thr) ||
                   (vertical_eye_height < veye_thr));
        events = '0;
        events[sih_pkg::EV_CABLE_LOSS] = link.cable_loss && !prev_cable_loss;
        events[sih_pkg::EV_CABLE_BACK] = !link.cable_loss && prev_cable_loss;
        events[sih_pkg::EV_TRACE_LOSS] = link.trace_loss && !prev_trace_loss;
        events[sih_pkg::EV_TRACE_BACK] = !link.trace_loss && prev_trace_loss;
        events[sih_pkg::EV_EYE_LOW]    = eye_low && !prev_eye_low;
        events[sih_pkg::EV_LOCK_GAIN]  = link.cdr_locked && !prev_lock;
        events[sih_pkg::EV_LOCK_LOST]  = !link.cdr_locked && prev_lock;
    end

    // Carrier is only reported once adaptation on that input has finished
    always_comb begin
        if (pin_cfg[sih_pkg::CFG_CD_SEL]) begin
            carrier_found_n = !(link.trace_carrier &&
                                link.trace_adapt_done);
        end else begin
            carrier_found_n = !(link.cable_carrier &&
                                link.cable_adapt_done);
        end
    end

    // Pin drive: oe high means pulling low
    always_comb begin
        case (role)
            sih_pkg::ROLE_CARRIER: begin
                next_status_pin_oe = !carrier_found_n;
            end
            sih_pkg::ROLE_INT: begin
                next_status_pin_oe = |(int_status & int_mask);
            end
            default: begin
                next_status_pin_oe = link.cdr_locked;
            end
        endcase
    end

    assign status_pin_o = 1'b0;

    // Length reading and mute
    always_comb begin
        if (cable_length_raw > sih_pkg::LEN_MAX) begin
            next_cable_length_reading = sih_pkg::LEN_MAX;
        end else begin
            next_cable_length_reading = cable_length_raw;
        end
        // Compare the registered reading so mute and readback agree
        next_outputs_muted =
            (cable_length_reading > mute_length_threshold);
    end

    // Register writes and sticky status
    always_comb begin
        next_mute_length_threshold = mute_length_threshold;
        next_pin_cfg               = pin_cfg;
        next_int_mask              = int_mask;
        next_heye_thr              = heye_thr;
        next_veye_thr              = veye_thr;
        next_int_status            = int_status;
        // Length reading and status have no write path, so writes there drop
        if (reg_req.wr) begin
            if (is_addr(reg_req.addr, sih_pkg::OFS_MUTE)) begin
                next_mute_length_threshold =
                    reg_req.wdata[LEN_W-1:0];
            end else if (is_addr(reg_req.addr, sih_pkg::OFS_PIN_CFG)) begin
                next_pin_cfg = reg_req.wdata[2:0];
            end else if (is_addr(reg_req.addr, sih_pkg::OFS_INT_MASK)) begin
                next_int_mask = reg_req.wdata[sih_pkg::EV_N-1:0];
            end else if (is_addr(reg_req.addr, sih_pkg::OFS_HEYE_THR)) begin
                next_heye_thr = reg_req.wdata[LEN_W-1:0];
            end else if (is_addr(reg_req.addr, sih_pkg::OFS_VEYE_THR)) begin
                next_veye_thr = reg_req.wdata[LEN_W-1:0];
            end
        end
        if (reg_req.rd && is_addr(reg_req.addr, sih_pkg::OFS_INT_STAT)) begin
            next_int_status = '0;
        end
        // A fresh event wins over the clearing read
        next_int_status = next_int_status | events;
    end

    // Read data
    always_comb begin
        next_reg_rvalid = reg_req.rd;
        next_reg_rdata  = sih_pkg::RD_ZERO;
        // Unmapped offsets answer zero
        if (reg_req.rd) begin
            if (is_addr(reg_req.addr, sih_pkg::OFS_MUTE)) begin
                next_reg_rdata[LEN_W-1:0] = mute_length_threshold;
            end else if (is_addr(reg_req.addr, sih_pkg::OFS_CABLE)) begin
                next_reg_rdata[LEN_W-1:0] = cable_length_reading;
            end else if (is_addr(reg_req.addr, sih_pkg::OFS_PIN_CFG)) begin
                next_reg_rdata[2:0] = pin_cfg;
                next_reg_rdata[sih_pkg::CFG_PIN_LVL] = status_pin_i;
            end else if (is_addr(reg_req.addr, sih_pkg::OFS_INT_MASK)) begin
                next_reg_rdata[sih_pkg::EV_N-1:0] = int_mask;
            end else if (is_addr(reg_req.addr, sih_pkg::OFS_INT_STAT)) begin
                next_reg_rdata[sih_pkg::EV_N-1:0] = int_status;
            end else if (is_addr(reg_req.addr, sih_pkg::OFS_HEYE_THR)) begin
                next_reg_rdata[LEN_W-1:0] = heye_thr;
            end else if (is_addr(reg_req.addr, sih_pkg::OFS_VEYE_THR)) begin
                next_reg_rdata[LEN_W-1:0] = veye_thr;
            end
        end
    end

    // Straps are caught once after reset; later changes are ignored
    always_comb begin
        next_host_port = host_port;
        if (!host_port.captured) begin
            next_host_port.captured   = 1'b1;
            next_host_port.smbus      =
                level_is(mode_sel_level, sih_pkg::LVL_LOW);
            next_host_port.spi        =
                level_is(mode_sel_level, sih_pkg::LVL_FLOAT) ||
                level_is(mode_sel_level, sih_pkg::LVL_HIGH);
            next_host_port.power_save =
                level_is(mode_sel_level, sih_pkg::LVL_HIGH);
            next_host_port.reserved   =
                level_is(mode_sel_level, sih_pkg::LVL_RES);
            next_host_port.slave_addr = sih_pkg::ADDR_BASE +
                sih_pkg::STRAP_STEP * {5'h00, addr_strap_first} +
                {5'h00, addr_strap_second};
            next_host_port.write_cmd  =
                {next_host_port.slave_addr, 1'b0};
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mute_length_threshold <= sih_pkg::RST_MUTE;
            pin_cfg               <= '0;
            int_mask              <= sih_pkg::RST_MASK;
            heye_thr              <= sih_pkg::RST_EYE_THR;
            veye_thr              <= sih_pkg::RST_EYE_THR;
        end else begin
            mute_length_threshold <= next_mute_length_threshold;
            pin_cfg               <= next_pin_cfg;
            int_mask              <= next_int_mask;
            heye_thr              <= next_heye_thr;
            veye_thr              <= next_veye_thr;
        end
    end

    // Sticky interrupt status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_status            <= '0;
        end else begin
            int_status            <= next_int_status;
        end
    end

    // Edge history resets to the idle input levels so no false edge follows
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_lock             <= 1'b0;
            prev_cable_loss       <= 1'b0;
            prev_trace_loss       <= 1'b0;
            prev_eye_low          <= 1'b0;
        end else begin
            prev_lock             <= link.cdr_locked;
            prev_cable_loss       <= link.cable_loss;
            prev_trace_loss       <= link.trace_loss;
            prev_eye_low          <= eye_low;
        end
    end

    // Read answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata             <= sih_pkg::RD_ZERO;
            reg_rvalid            <= 1'b0;
        end else begin
            reg_rdata             <= next_reg_rdata;
            reg_rvalid            <= next_reg_rvalid;
        end
    end

    // Length reading, pin drive and mute
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cable_length_reading  <= '0;
            status_pin_oe         <= 1'b0;
            outputs_muted         <= 1'b0;
        end else begin
            cable_length_reading  <= next_cable_length_reading;
            status_pin_oe         <= next_status_pin_oe;
            outputs_muted         <= next_outputs_muted;
        end
    end

    // Strap capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_port             <= '0;
        end else begin
            host_port             <= next_host_port;
        end
    end

endmodule // sih_status

// file: core/sih_pkg.sv
// Constants, register map and carrier types for the status/interrupt block.
// Assumes a single 100 MHz clock; register port framing is done upstream.
package sih_pkg;

    localparam int DW = 8;
    localparam int LEN_W = 6;
    localparam int EV_N = 7;

    // Register offsets
    localparam logic [7:0] OFS_MUTE     = 8'h03;
    localparam logic [7:0] OFS_CABLE    = 8'h25;
    localparam logic [7:0] OFS_PIN_CFG  = 8'h40;
    localparam logic [7:0] OFS_INT_MASK = 8'h41;
    localparam logic [7:0] OFS_INT_STAT = 8'h42;
    localparam logic [7:0] OFS_HEYE_THR = 8'h43;
    localparam logic [7:0] OFS_VEYE_THR = 8'h44;

    // Reset values and limits
    localparam logic [5:0] LEN_MAX     = 6'h37;
    localparam logic [5:0] RST_MUTE    = 6'h37;
    localparam logic [5:0] RST_EYE_THR = 6'h00;
    localparam logic [6:0] RST_MASK    = 7'h00;
    localparam logic [7:0] RD_ZERO     = 8'h00;

    // Pin configuration fields
    localparam int CFG_ROLE_LSB = 0;
    localparam int CFG_CD_SEL   = 2;
    localparam int CFG_PIN_LVL  = 7;

    // Interrupt event bit positions
    localparam int EV_CABLE_LOSS = 0;
    localparam int EV_CABLE_BACK = 1;
    localparam int EV_TRACE_LOSS = 2;
    localparam int EV_TRACE_BACK = 3;
    localparam int EV_EYE_LOW    = 4;
    localparam int EV_LOCK_GAIN  = 5;
    localparam int EV_LOCK_LOST  = 6;

    // Slave address arithmetic
    localparam logic [6:0] ADDR_BASE  = 7'h1d;
    localparam logic [6:0] STRAP_STEP = 7'h04;

    typedef enum logic [1:0] {
        ROLE_LOCK    = 2'b00,
        ROLE_CARRIER = 2'b01,
        ROLE_INT     = 2'b10,
        ROLE_SPARE   = 2'b11
    } sih_role_t;

    typedef enum logic [1:0] {
        LVL_LOW   = 2'b00,
        LVL_RES   = 2'b01,
        LVL_FLOAT = 2'b10,
        LVL_HIGH  = 2'b11
    } sih_level_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sih_reg_req_t;

    typedef struct packed {
        logic cdr_locked;
        logic cable_loss;
        logic trace_loss;
        logic cable_carrier;
        logic trace_carrier;
        logic cable_adapt_done;
        logic trace_adapt_done;
    } sih_link_t;

    typedef struct packed {
        logic       captured;
        logic       smbus;
        logic       spi;
        logic       power_save;
        logic       reserved;
        logic [6:0] slave_addr;
        logic [7:0] write_cmd;
    } sih_host_port_t;

endpackage

// file: testbench/sih_status_checker.sv
// Port-level checker for the status pin, mute, register answer and straps.
// Assumes one clock; shadow copies of the config follow writes seen at the port.
`timescale 1ns/10ps
module sih_status_checker #(
    parameter int LEN_W = sih_pkg::LEN_W
) (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire sih_pkg::sih_reg_req_t  reg_req,
    input wire logic                   reg_rvalid,
    input wire sih_pkg::sih_link_t     link,
    input wire logic [LEN_W-1:0]       cable_length_raw,
    input wire logic [1:0]             mode_sel_level,
    input wire logic [1:0]             addr_strap_first,
    input wire logic [1:0]             addr_strap_second,
    input wire logic                   status_pin_o,
    input wire logic                   status_pin_oe,
    input wire logic                   outputs_muted,
    input wire sih_pkg::sih_host_port_t host_port
);
    logic [1:0]       cnt, next_cnt;
    logic [7:0]       cfg, next_cfg;
    logic [5:0]       thr, next_thr;
    logic [LEN_W-1:0] len;
    logic             cfgw, clr;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_comb begin
        next_cnt = (cnt == 2'h3) ? cnt : cnt + 2'h1;
        next_cfg = (reg_req.wr && reg_req.addr == sih_pkg::OFS_PIN_CFG) ? reg_req.wdata : cfg;
        next_thr = (reg_req.wr && reg_req.addr == sih_pkg::OFS_MUTE) ? reg_req.wdata[5:0] : thr;
        len  = (cable_length_raw > sih_pkg::LEN_MAX) ? sih_pkg::LEN_MAX : cable_length_raw;
        cfgw = reg_req.wr && reg_req.addr inside {sih_pkg::OFS_PIN_CFG, sih_pkg::OFS_INT_MASK};
        clr  = reg_req.rd && reg_req.addr == sih_pkg::OFS_INT_STAT;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 2'h0;
            cfg <= 8'h00;
            thr <= sih_pkg::RST_MUTE;
        end else begin
            cnt <= next_cnt;
            cfg <= next_cfg;
            thr <= next_thr;
        end
    end
    AST_OPEN_DRAIN: assert property (status_pin_o == 1'b0)
        else $error("status pin driven high");
    AST_LOCK_ROLE: assert property (cnt != 2'h0 && $past(cfg[1:0]) inside
        {sih_pkg::ROLE_LOCK, sih_pkg::ROLE_SPARE} |-> status_pin_oe == $past(link.cdr_locked))
        else $error("lock role pin wrong");
    AST_CARRIER_ROLE: assert property (cnt != 2'h0 && $past(cfg[1:0]) == sih_pkg::ROLE_CARRIER
        |-> status_pin_oe == $past(cfg[2] ? (link.trace_carrier && link.trace_adapt_done)
        : (link.cable_carrier && link.cable_adapt_done))) else $error("carrier role pin wrong");
    AST_STICKY: assert property (cnt == 2'h3 && $past(cfg[1:0]) == sih_pkg::ROLE_INT
        && $past(cfg[1:0], 2) == sih_pkg::ROLE_INT && $past(status_pin_oe) && !$past(cfgw, 2)
        && !$past(clr, 2) |-> status_pin_oe) else $error("interrupt released without read");
    AST_READ_ANSWER: assert property (cnt != 2'h0 |-> reg_rvalid == $past(reg_req.rd))
        else $error("read answer timing wrong");
    AST_MUTE: assert property (cnt >= 2'h2 |-> outputs_muted == ($past(len, 2) > $past(thr)))
        else $error("mute state wrong");
    AST_PORT_SEL: assert property ($rose(host_port.captured) |->
        host_port.smbus == ($past(mode_sel_level) == sih_pkg::LVL_LOW)
        && host_port.spi == ($past(mode_sel_level) inside {sih_pkg::LVL_FLOAT, sih_pkg::LVL_HIGH})
        && host_port.power_save == ($past(mode_sel_level) == sih_pkg::LVL_HIGH))
        else $error("port select decode wrong");
    AST_SLAVE_ADDR: assert property ($rose(host_port.captured) |-> host_port.slave_addr ==
        sih_pkg::ADDR_BASE + sih_pkg::STRAP_STEP * $past(addr_strap_first)
        + $past(addr_strap_second)) else $error("slave address wrong");
    AST_WRITE_CMD: assert property (host_port.captured |->
        host_port.write_cmd == {host_port.slave_addr, 1'b0}) else $error("write command wrong");
    AST_PORT_HELD: assert property (host_port.captured |=> $stable(host_port))
        else $error("strap capture changed");
    cover property (clr ##1 reg_rvalid);
    cover property ($rose(outputs_muted));
    cover property ($past(cfg[1:0]) == sih_pkg::ROLE_INT && $rose(status_pin_oe));
endmodule // sih_status_checker

// file: testbench/sih_host_model.sv
// Host controller model: one register request at a time, plus the pin pull-up.
// Assumes requests are launched at the falling edge of clk.
`timescale 1ns/10ps
module sih_host_model (
    input  wire logic             clk,
    output sih_pkg::sih_reg_req_t reg_req,
    input  wire logic [7:0]       reg_rdata,
    input  wire logic             reg_rvalid,
    input  wire logic             status_pin_o,
    input  wire logic             status_pin_oe,
    output logic                  pin_level
);
    assign pin_level = status_pin_oe ? status_pin_o : 1'b1;
    initial reg_req = '0;
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req = {w, !w, a, d};
        @(negedge clk);
        // Released bus shows junk so a stale address cannot pass for a live one
        reg_req = {2'b00, ~a, ~d};
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        put(1'b0, a, 8'h00);
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask
    task automatic calibrate();
        logic [7:0] len;
        get(sih_pkg::OFS_CABLE, len);
        put(1'b1, sih_pkg::OFS_MUTE, len);
    endtask
endmodule // sih_host_model

// file: testbench/tb_top.sv
// Bench top: strap sweep, length and mute, pin roles and sticky interrupts.
// Assumes the checker is bound below and the host model issues requests.
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_top;
    logic                    clk = 1'b0;
    logic                    rst_n = 1'b0;
    sih_pkg::sih_reg_req_t   reg_req;
    sih_pkg::sih_link_t      link = '0;
    sih_pkg::sih_host_port_t hp;
    logic [7:0]              rdata, d;
    logic                    rvalid, pin_o, pin_oe, pin, muted;
    logic [5:0]              heye = 6'h3f, veye = 6'h3f, raw = 6'h00, thr;
    logic [1:0]              msel = 2'h0, s0 = 2'h0, s1 = 2'h0;
    int                      err_count = 0, comparisons = 0;
    always #5 clk = ~clk;
    sih_status i_sih_status (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .link(link), .horizontal_eye_width(heye),
        .vertical_eye_height(veye), .cable_length_raw(raw), .mode_sel_level(msel),
        .addr_strap_first(s0), .addr_strap_second(s1), .status_pin_i(pin),
        .status_pin_o(pin_o), .status_pin_oe(pin_oe), .outputs_muted(muted), .host_port(hp));
    sih_host_model i_sih_host_model (.clk(clk), .reg_req(reg_req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .status_pin_o(pin_o), .status_pin_oe(pin_oe), .pin_level(pin));
    function automatic logic [6:0] exp_addr(input logic [1:0] a, input logic [1:0] b);
        return 7'h1d + {3'h0, a, 2'h0} + {5'h0, b};
    endfunction
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Drives link to the state before (p=0) or after (p=1) event number k
    // k=7 raises the eye event again, through the vertical opening
    task automatic stim(input int k, input logic p);
        @(negedge clk);
        link.cable_loss = (k == 0) ? p : (k == 1) ? !p : 1'b0;
        link.trace_loss = (k == 2) ? p : (k == 3) ? !p : 1'b0;
        link.cdr_locked = (k == 4) || (k == 7) || ((k == 5) ? p : (k == 6) ? !p : 1'b0);
        heye = (k == 4 && p) ? 6'h05 : 6'h3f;
        veye = (k == 7 && p) ? 6'h05 : 6'h3f;
    endtask
    initial begin
        void'($urandom(32'hbb094ed8));
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            rst_n = 1'b0;
            {s0, s1} = i[3:0];
            msel = i[1:0];
            wait_n(3);
            rst_n = 1'b1;
            wait_n(2);
            `CHK(hp.slave_addr, exp_addr(s0, s1))
            `CHK(hp.write_cmd, {exp_addr(s0, s1), 1'b0})
            `CHK(hp.smbus, msel == 2'h0)
            `CHK(hp.reserved, msel == 2'h1)
            `CHK(hp.spi, msel[1])
            `CHK(hp.power_save, msel == 2'h3)
        end
        i_sih_host_model.get(sih_pkg::OFS_MUTE, d);
        `CHK(d, 8'h37)
        i_sih_host_model.get(8'h7e, d);
        `CHK(d, 8'h00)
        for (int i = 0; i < 20; i++) begin
            thr = 6'($urandom);
            i_sih_host_model.put(1'b1, sih_pkg::OFS_MUTE, {2'b00, thr});
            raw = (i == 0) ? 6'h3f : 6'($urandom);
            wait_n(3);
            i_sih_host_model.get(sih_pkg::OFS_CABLE, d);
            `CHK(d, {2'b00, (raw > 6'd55) ? 6'd55 : raw})
            `CHK(muted, ((raw > 6'd55) ? 6'd55 : raw) > thr)
        end
        raw = 6'd30;
        wait_n(2);
        i_sih_host_model.calibrate();
        wait_n(3);
        `CHK(muted, 1'b0)
        raw = 6'd31;
        wait_n(3);
        `CHK(muted, 1'b1)
        stim(5, 1);
        wait_n(2);
        `CHK(pin, 1'b0)
        i_sih_host_model.put(1'b1, sih_pkg::OFS_PIN_CFG, 8'h03);
        wait_n(3);
        `CHK(pin, 1'b0)
        i_sih_host_model.put(1'b1, sih_pkg::OFS_PIN_CFG, 8'h01);
        link.cable_carrier = 1'b1;
        wait_n(3);
        `CHK(pin, 1'b1)
        i_sih_host_model.get(sih_pkg::OFS_PIN_CFG, d);
        `CHK(d, 8'h81)
        link.cable_adapt_done = 1'b1;
        wait_n(3);
        `CHK(pin, 1'b0)
        i_sih_host_model.put(1'b1, sih_pkg::OFS_PIN_CFG, 8'h05);
        wait_n(3);
        `CHK(pin, 1'b1)
        i_sih_host_model.put(1'b1, sih_pkg::OFS_HEYE_THR, 8'h20);
        i_sih_host_model.put(1'b1, sih_pkg::OFS_VEYE_THR, 8'h20);
        i_sih_host_model.get(sih_pkg::OFS_VEYE_THR, d);
        `CHK(d, 8'h20)
        i_sih_host_model.put(1'b1, sih_pkg::OFS_PIN_CFG, 8'h02);
        for (int k = 0; k < 8; k++) begin
            int b;
            b = (k == 7) ? sih_pkg::EV_EYE_LOW : k;
            stim(k, 1'b0);
            i_sih_host_model.put(1'b1, sih_pkg::OFS_INT_MASK, 8'h01 << b);
            i_sih_host_model.get(sih_pkg::OFS_INT_STAT, d);
            wait_n(3);
            `CHK(pin, 1'b1)
            stim(k, 1'b1);
            wait_n(3);
            `CHK(pin, 1'b0)
            i_sih_host_model.get(sih_pkg::OFS_INT_STAT, d);
            `CHK(d[b], 1'b1)
            wait_n(3);
            `CHK(pin, 1'b1)
        end
        stop_test();
    end
    initial begin
        #200us;
        err_count++;
        stop_test();
    end
endmodule // tb_top
bind sih_status sih_status_checker #(.LEN_W(LEN_W)) i_chk (.clk(clk), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rvalid(reg_rvalid), .link(link), .cable_length_raw(cable_length_raw),
    .mode_sel_level(mode_sel_level), .addr_strap_first(addr_strap_first),
    .addr_strap_second(addr_strap_second), .status_pin_o(status_pin_o),
    .status_pin_oe(status_pin_oe), .outputs_muted(outputs_muted), .host_port(host_port));
